// File: rtl/line_out_pkg.sv
package line_out_pkg;
  // ==========================================
  // line format
  localparam int PIXELS_PER_LINE = 2098;
  localparam int SLOT_W = 10;
  localparam int NARROW_W = 8;
  localparam int DROP_LSB = 2;
  localparam int CYCLES_PER_PIXEL = 2;
  localparam int PIX_CNT_W = 12;
  localparam int FIFO_DEPTH = 4;
  // ==========================================
  // timing
  localparam real PCLK_MHZ = 40.0;
  localparam real CLK_MHZ = 100.0;
  localparam int PCLK_HALF_MAX_CYC = 2;
  // ==========================================
  // serial framing
  localparam int UART_DATA_BITS = 8;
  localparam int UART_STOP_BITS = 1;
  localparam bit UART_PARITY_EN = 1'b0;
  localparam int UART_DIV_DEFAULT = 868;
  localparam int UART_DIV_W = 16;
  localparam logic [7:0] CMD_QUERY = 8'h3F;
  localparam logic [7:0] CMD_SET_8BIT = 8'h38;
  localparam logic [7:0] CMD_SET_10BIT = 8'h30;
  localparam logic [7:0] CMD_AOI_BASE = 8'h80;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [SLOT_W-1:0] FILLER = 10'h000;

  typedef struct packed {
    logic [SLOT_W-1:0] red;
    logic [SLOT_W-1:0] green;
    logic [SLOT_W-1:0] blue;
  } rgb_s;

  typedef struct packed {
    logic line_valid;
    logic [SLOT_W-1:0] slot_a;
    logic [SLOT_W-1:0] slot_b;
  } video_word_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RG = 2'b01,
    ST_BF = 2'b10
  } tx_state_e;

  typedef enum logic [1:0] {
    US_IDLE = 2'b00,
    US_DATA = 2'b01,
    US_STOP = 2'b10
  } uart_state_e;
endpackage

// File: rtl/dual_pixel_rgb_line_output.sv
`timescale 1ns/10ps
// Overview of operation
// RULE1 - pixel clock runs at 40 MHz, one word sent each cycle.
// RULE2 - each cycle carries two 10-bit slots plus one line valid bit.
// RULE3 - every output word changes on the pixel clock falling edge.
// RULE4 - slot contents mean something only while line valid is high.
// RULE5 - 8-bit variant drops the two low bits of each sample.
// RULE6 - line valid stays low whenever no line is being sent.
// RULE7 - a line is sent only after its acquisition completes.
// RULE8 - first valid cycle: slot A red, slot B green of pixel one.
// RULE9 - second valid cycle: slot A blue of pixel one, slot B filler.
// RULE10 - the two-cycle pattern repeats for every following pixel.
// RULE11 - full line is 4196 valid cycles, 2098 pixels.
// RULE12 - line valid drops after the final pixel is sent.
// RULE13 - receiver discards slot B of every even valid cycle.
// RULE14 - colours of each pixel go out red, green, blue.
// RULE15 - area of interest may shorten the line and valid period.
// RULE16 - exposure active output follows the exposure window.
// RULE17 - serial link framing is 8 data bits, no parity, one stop.
// RULE18 - serial commands change setup; queries report current setup.
// RULE19 - filler slot is zero; 8-bit data sits in the low slot bits.
// RULE20 - a rising external trigger edge starts line readout.

// ==========================================
// small pixel fifo
module pixel_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      count <= (AW+1)'(count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
    end
  end
endmodule // pixel_fifo

// ==========================================
// line output formatter
module dual_pixel_rgb_line_output
  import line_out_pkg::*;
#(
  parameter int PIXELS = PIXELS_PER_LINE,
  parameter int UART_DIV = UART_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pixel_clk,
  input wire logic external_line_trigger,
  input wire logic acq_done,
  input wire logic exposure_on,
  input wire line_out_pkg::rgb_s pix_in,
  input wire logic pix_in_valid,
  output logic pix_in_ready,
  output line_out_pkg::video_word_s video_out,
  output logic exposure_active_out,
  output logic readout_start,
  input wire logic ser_rx,
  output logic ser_tx,
  output logic narrow_mode
);
  import line_out_pkg::*;

  function automatic logic [SLOT_W-1:0] fmt(input logic [SLOT_W-1:0] s, input logic n);
    fmt = n ? {{DROP_LSB{1'b0}}, s[SLOT_W-1:DROP_LSB]} : s;
  endfunction

  // ==========================================
  // pin synchronisers: three stages, change on stage 2/3 agreement
  logic [2:0] pclk_sync;
  logic [2:0] trig_sync;
  logic [2:0] rx_sync;
  logic pclk_lvl;
  logic trig_lvl;
  logic rx_lvl;
  logic pclk_fall;
  logic trig_rise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pclk_sync <= 3'b000;
      trig_sync <= 3'b000;
      rx_sync <= 3'b111;
    end else begin
      pclk_sync <= {pclk_sync[1:0], pixel_clk};
      trig_sync <= {trig_sync[1:0], external_line_trigger};
      rx_sync <= {rx_sync[1:0], ser_rx};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pclk_lvl <= 1'b0;
      trig_lvl <= 1'b0;
      rx_lvl <= 1'b1;
    end else begin
      if (pclk_sync[1] == pclk_sync[2]) pclk_lvl <= pclk_sync[2];
      if (trig_sync[1] == trig_sync[2]) trig_lvl <= trig_sync[2];
      if (rx_sync[1] == rx_sync[2]) rx_lvl <= rx_sync[2];
    end
  end

  // one-cycle edge flags from the filtered levels
  assign pclk_fall = pclk_lvl && (pclk_sync[1] == pclk_sync[2]) && !pclk_sync[2]; // RULE3
  assign trig_rise = !trig_lvl && (trig_sync[1] == trig_sync[2]) && trig_sync[2]; // RULE20

  // ==========================================
  // setup state, written over the serial link
  logic [PIX_CNT_W-1:0] aoi_pixels;
  logic rx_done;
  logic [7:0] rx_byte;
  logic tx_req;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      narrow_mode <= 1'b0;
      aoi_pixels <= PIX_CNT_W'(PIXELS);
      tx_req <= 1'b0;
    end else begin
      tx_req <= 1'b0;
      if (rx_done) begin
        if (rx_byte == CMD_SET_8BIT) narrow_mode <= 1'b1; // RULE18
        else if (rx_byte == CMD_SET_10BIT) narrow_mode <= 1'b0;
        else if (rx_byte == CMD_QUERY) tx_req <= 1'b1;
        else if (rx_byte >= CMD_AOI_BASE) begin
          // aoi in steps of 16 pixels, 0 restores full line
          aoi_pixels <= (rx_byte == CMD_AOI_BASE) ? PIX_CNT_W'(PIXELS) :
                        PIX_CNT_W'({rx_byte[6:0], 4'h0}); // RULE15
        end
      end
    end
  end

  // ==========================================
  // serial receiver, 8N1
  uart_state_e rx_state;
  logic [UART_DIV_W-1:0] rx_cnt;
  logic [3:0] rx_bit;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_state <= US_IDLE;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_byte <= ZERO_BYTE;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_state)
        US_IDLE: begin
          if (!rx_lvl) begin
            rx_state <= US_DATA;
            rx_cnt <= UART_DIV_W'(UART_DIV + UART_DIV / 2);
            rx_bit <= '0;
          end
        end
        US_DATA: begin
          if (rx_cnt == '0) begin
            rx_byte <= {rx_lvl, rx_byte[7:1]}; // RULE17
            rx_cnt <= UART_DIV_W'(UART_DIV - 1);
            rx_bit <= 4'(rx_bit + 1'b1);
            if (rx_bit == 4'(UART_DATA_BITS - 1)) rx_state <= US_STOP;
          end else begin
            rx_cnt <= UART_DIV_W'(rx_cnt - 1'b1);
          end
        end
        US_STOP: begin
          if (rx_cnt == '0) begin
            rx_done <= rx_lvl; // bad stop bit drops the byte
            rx_state <= US_IDLE;
          end else begin
            rx_cnt <= UART_DIV_W'(rx_cnt - 1'b1);
          end
        end
        default: rx_state <= US_IDLE;
      endcase
    end
  end

  // ==========================================
  // serial transmitter: answers a query with the setup byte
  logic [9:0] tx_shift;
  logic [3:0] tx_left;
  logic [UART_DIV_W-1:0] tx_cnt;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_shift <= 10'h3FF;
      tx_left <= '0;
      tx_cnt <= '0;
    end else if (tx_left == '0) begin
      if (tx_req) begin
        tx_shift <= {1'b1, narrow_mode, aoi_pixels[10:4], 1'b0}; // RULE17 RULE18
        tx_left <= 4'(UART_DATA_BITS + UART_STOP_BITS + 1);
        tx_cnt <= UART_DIV_W'(UART_DIV - 1);
      end
    end else if (tx_cnt == '0) begin
      tx_shift <= {1'b1, tx_shift[9:1]};
      tx_left <= 4'(tx_left - 1'b1);
      tx_cnt <= UART_DIV_W'(UART_DIV - 1);
    end else begin
      tx_cnt <= UART_DIV_W'(tx_cnt - 1'b1);
    end
  end

  assign ser_tx = tx_shift[0];

  // ==========================================
  // exposure and readout
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exposure_active_out <= 1'b0;
      readout_start <= 1'b0;
    end else begin
      exposure_active_out <= exposure_on; // RULE16
      readout_start <= trig_rise; // RULE20
    end
  end

  // ==========================================
  // line sender: one word per falling pixel clock edge
  tx_state_e state;
  logic [PIX_CNT_W-1:0] pix_cnt;
  logic line_pending;
  rgb_s fifo_out;
  logic fifo_valid;
  logic fifo_pop;

  // acquisition done held until the sender picks it up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_pending <= 1'b0;
    end else if (acq_done) begin
      line_pending <= 1'b1; // RULE7
    end else if (pclk_fall && state == ST_IDLE && fifo_valid) begin
      line_pending <= 1'b0;
    end
  end

  // the blue half pops; stalls upstream while the fifo is full
  assign fifo_pop = pclk_fall && state == ST_RG;

  pixel_fifo #(
    .WIDTH($bits(rgb_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(pix_in),
    .in_valid(pix_in_valid),
    .in_ready(pix_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      pix_cnt <= '0;
      video_out <= '0;
    end else if (pclk_fall) begin
      case (state)
        ST_IDLE: begin
          video_out <= '0; // RULE6
          if (line_pending && fifo_valid) begin
            video_out.line_valid <= 1'b1; // RULE1 RULE2
            video_out.slot_a <= fmt(fifo_out.red, narrow_mode); // RULE8 RULE14 RULE5 RULE19
            video_out.slot_b <= fmt(fifo_out.green, narrow_mode); // RULE8
            pix_cnt <= PIX_CNT_W'(1);
            state <= ST_RG;
          end
        end
        ST_RG: begin
          video_out.line_valid <= 1'b1;
          video_out.slot_a <= fmt(fifo_out.blue, narrow_mode); // RULE9 RULE14
          video_out.slot_b <= FILLER; // RULE9 RULE13 RULE19
          state <= ST_BF;
        end
        ST_BF: begin
          if (pix_cnt >= aoi_pixels || pix_cnt >= PIX_CNT_W'(PIXELS) || !fifo_valid) begin
            video_out <= '0; // RULE12 RULE11 RULE4
            state <= ST_IDLE;
          end else begin
            video_out.line_valid <= 1'b1; // RULE10
            video_out.slot_a <= fmt(fifo_out.red, narrow_mode);
            video_out.slot_b <= fmt(fifo_out.green, narrow_mode);
            pix_cnt <= PIX_CNT_W'(pix_cnt + 1'b1);
            state <= ST_RG;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // checks
  a_word_on_fall: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    $changed(video_out) |-> $past(pclk_fall))
    else $error("video word changed off a falling pixel clock edge");
  a_filler_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
    (state == ST_BF) |-> (video_out.slot_b == FILLER && video_out.line_valid))
    else $error("filler slot not zero");
  a_idle_low: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    (state == ST_IDLE) |-> !video_out.line_valid)
    else $error("line valid high while idle");
  a_rg_then_bf: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    (state == ST_RG && pclk_fall) |=> (state == ST_BF))
    else $error("red green not followed by blue");
  a_narrow_low: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    (narrow_mode && video_out.line_valid && state == ST_RG && $past(pclk_fall))
      |-> video_out.slot_a[SLOT_W-1:NARROW_W] == '0)
    else $error("narrow slot upper bits not zero");
  a_count_bound: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    pix_cnt <= PIX_CNT_W'(PIXELS))
    else $error("pixel count beyond line length");
  a_start_pending: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    ($rose(state == ST_RG) && $past(state) == ST_IDLE) |-> $past(line_pending))
    else $error("line started without completed acquisition");
  a_exposure_follow: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
    ##1 exposure_active_out == $past(exposure_on))
    else $error("exposure output does not follow exposure");
  a_trigger_readout: assert property (@(posedge clk) disable iff (!rst_n) // RULE20
    trig_rise |=> readout_start ##1 !readout_start)
    else $error("readout pulse missing after trigger edge");
endmodule // dual_pixel_rgb_line_output

// File: dv/grabber_model.sv
`timescale 1ns/10ps
// ==========================================
// frame grabber side: video capture, serial port
module grabber_model
  import line_out_pkg::*;
#(
  parameter int DIV = 8
) (
  input wire logic clk,
  input wire logic pixel_clk,
  input wire line_out_pkg::video_word_s video_out,
  input wire logic ser_tx,
  output logic ser_rx
);
  video_word_s words[$];
  initial ser_rx = 1'b1;
  // word is stable at the next fall, its own launch lags the pin
  always @(negedge pixel_clk) begin
    if (video_out.line_valid === 1'b1) begin
      words.push_back(video_out);
    end
  end
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      ser_rx = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (DIV - 1) @(negedge clk);
    end
  endtask
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = '0;
    ok = 1'b0;
    // sampled off the launching edge, so the line has settled
    while (ser_tx !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n < 2000) begin
      repeat (DIV / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(negedge clk);
        b[i] = ser_tx;
      end
      repeat (DIV) @(negedge clk);
      ok = (ser_tx === 1'b1);
    end
  endtask
endmodule // grabber_model

// File: dv/dual_pixel_rgb_line_output_tb.sv
`timescale 1ns/10ps
module dual_pixel_rgb_line_output_tb;
  import line_out_pkg::*;
  // short line keeps the run small
  localparam int PIX = 20;
  // one area of interest step, shorter than the full test line
  localparam int PIX_AOI = 16;
  logic clk, rst_n, pixel_clk, external_line_trigger, acq_done, exposure_on;
  logic pix_in_valid, pix_in_ready, exposure_active_out, readout_start, ser_rx, ser_tx, narrow_mode;
  rgb_s pix_in;
  video_word_s video_out;
  int error_cnt, comparisons, cyc;

  initial clk = 1'b0;
  always #5 clk = ~clk;
  // link clock, unrelated phase
  initial begin
    pixel_clk = 1'b0;
    #3;
    forever #40 pixel_clk = ~pixel_clk;
  end

  dual_pixel_rgb_line_output #(.PIXELS(PIX), .UART_DIV(8)) i_dual_pixel_rgb_line_output (
    .clk(clk), .rst_n(rst_n), .pixel_clk(pixel_clk), .external_line_trigger(external_line_trigger),
    .acq_done(acq_done), .exposure_on(exposure_on), .pix_in(pix_in), .pix_in_valid(pix_in_valid),
    .pix_in_ready(pix_in_ready), .video_out(video_out), .exposure_active_out(exposure_active_out),
    .readout_start(readout_start), .ser_rx(ser_rx), .ser_tx(ser_tx), .narrow_mode(narrow_mode));
  grabber_model #(.DIV(8)) i_grabber_model (
    .clk(clk), .pixel_clk(pixel_clk), .video_out(video_out), .ser_tx(ser_tx), .ser_rx(ser_rx));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic rgb_s mk(input int i);
    mk.red = 10'h2C1 + 10'(i * 5);
    mk.green = 10'h1B6 + 10'(i * 3);
    mk.blue = 10'h0A7 + 10'(i * 7);
  endfunction

  function automatic logic [SLOT_W-1:0] sl(input logic [SLOT_W-1:0] v, input logic nar);
    return nar ? {2'h0, v[SLOT_W-1:DROP_LSB]} : v;
  endfunction

  task automatic push(input rgb_s p);
    int n;
    n = 0;
    @(negedge clk);
    pix_in = p;
    pix_in_valid = 1'b1;
    while (pix_in_ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    @(negedge clk);
    pix_in_valid = 1'b0;
    if (n == 400) chk(1'b0, "pixel push stuck");
  endtask

  task automatic run_line(input int n, input int m, input logic nar, input logic hold);
    int k, t;
    rgb_s p;
    i_grabber_model.words.delete();
    for (k = 0; k < n && k < FIFO_DEPTH; k++) push(mk(k));
    if (hold) begin
      chk(pix_in_ready === 1'b0, "full fifo still ready");
      repeat (100) @(negedge clk);
      chk(i_grabber_model.words.size() == 0, "line sent before acquisition done");
    end
    @(negedge clk);
    acq_done = 1'b1;
    @(negedge clk);
    acq_done = 1'b0;
    for (; k < n; k++) push(mk(k));
    t = 0;
    while (i_grabber_model.words.size() < 2 * m && t < 2000) begin
      @(negedge clk);
      t++;
    end
    repeat (40) @(negedge clk);
    chk(video_out.line_valid === 1'b0, "line valid stuck high");
    chk(i_grabber_model.words.size() == 2 * m, "valid word count");
    for (k = 0; k < m && 2 * k + 1 < i_grabber_model.words.size(); k++) begin
      p = mk(k);
      chk(i_grabber_model.words[2*k] === {1'b1, sl(p.red, nar), sl(p.green, nar)}, "red green word");
      chk(i_grabber_model.words[2*k+1] === {1'b1, sl(p.blue, nar), FILLER}, "blue filler word");
    end
  endtask

  task automatic serial_mode();
    logic [7:0] b;
    logic ok;
    chk(narrow_mode === 1'b0, "mode after reset");
    i_grabber_model.send_byte(CMD_SET_8BIT);
    repeat (20) @(negedge clk);
    chk(narrow_mode === 1'b1, "8-bit mode not set");
    fork
      i_grabber_model.send_byte(CMD_QUERY);
      i_grabber_model.recv_byte(b, ok);
    join
    chk(ok === 1'b1 && b === {1'b1, 7'(PIX / 16)}, "query reply");
  endtask

  task automatic aoi_line();
    i_grabber_model.send_byte(CMD_SET_10BIT);
    i_grabber_model.send_byte(CMD_AOI_BASE | 8'h01);
    repeat (20) @(negedge clk);
    chk(narrow_mode === 1'b0, "10-bit mode not set");
    // one spare pixel queued, so only the window can end the line
    run_line(PIX_AOI + 1, PIX_AOI, 1'b0, 1'b0);
  endtask

  task automatic exposure_check();
    @(negedge clk);
    exposure_on = 1'b1;
    @(negedge clk);
    chk(exposure_active_out === 1'b1, "exposure rise");
    repeat (5) @(negedge clk);
    exposure_on = 1'b0;
    @(negedge clk);
    chk(exposure_active_out === 1'b0, "exposure fall");
  endtask

  task automatic trigger_check();
    int t;
    t = 0;
    @(negedge clk);
    external_line_trigger = 1'b1;
    while (readout_start !== 1'b1 && t < 10) begin
      @(negedge clk);
      t++;
    end
    chk(t < 10, "no readout start");
    @(negedge clk);
    chk(readout_start === 1'b0, "readout pulse too long");
    repeat (10) @(negedge clk);
    chk(readout_start === 1'b0, "readout on steady level");
    external_line_trigger = 1'b0;
  endtask

  initial begin
    cyc = 0;
    error_cnt = 0;
    comparisons = 0;
    rst_n = 1'b0;
    external_line_trigger = 1'b0;
    acq_done = 1'b0;
    exposure_on = 1'b0;
    pix_in = '0;
    pix_in_valid = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    run_line(PIX, PIX, 1'b0, 1'b1);
    serial_mode();
    run_line(2, 2, 1'b1, 1'b0);
    aoi_line();
    exposure_check();
    trigger_check();
    complete_run();
  end
endmodule // dual_pixel_rgb_line_output_tb
